// file: cms_defs.vh
// Purpose : Constants for the CRC memory scanner: register offsets, fields, resets.
// Assumes : Byte-wide register port, 12-bit byte address.
// Notes   : Definitions only; included by the scanner top module.
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CMS_OFS_POLY_L   12'h352
`define CMS_OFS_POLY_H   12'h353
`define CMS_OFS_POLY_U   12'h354
`define CMS_OFS_POLY_T   12'h355
`define CMS_OFS_CTRL     12'h360
`define CMS_OFS_TRIGGER_SOURCE_CODE     12'h361
`define CMS_OFS_CUR_L    12'h362
`define CMS_OFS_CUR_H    12'h363
`define CMS_OFS_CUR_U    12'h364
`define CMS_OFS_END_L    12'h365
`define CMS_OFS_END_H    12'h366
`define CMS_OFS_END_U    12'h367

// ----------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------
`define CMS_BIT_EN       7
`define CMS_BIT_SCANNER_TRIGGER_ENABLE   6
`define CMS_BIT_GO       5
`define CMS_BIT_REGION   2
`define CMS_BIT_BURST    1
`define CMS_BIT_BUSY     0

// ----------------------------------------------------------------------
// Reset values and highest used trigger code
// ----------------------------------------------------------------------
`define CMS_POLY_RST     32'h0000_0000
`define CMS_CTRL_RST     8'h04
`define CMS_TRIGGER_SOURCE_CODE_RST     4'h0
`define CMS_CUR_RST      22'h00_0000
`define CMS_END_RST      22'h3f_ffff
`define CMS_TRIG_USED    4'hb

`endif

// file: cms_sync.v
// Purpose : Two-flop synchroniser for a bundle of level inputs.
// Assumes : Inputs are asynchronous to clk_sys_in.
// Notes   : First stage feeds only the second stage.
`timescale 1ns/1ps
module cms_sync #(
  parameter WIDTH = 12
) (
  input  wire             clk_sys_in,
  input  wire             rst_n_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // Two stages; the first is read by nothing else
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: cms_fifo.v
// Purpose : Word FIFO between memory fetch and CRC engine.
// Assumes : Single clock; DEPTH is a power of two.
// Notes   : Read word and valid come from registers (output stage).
`timescale 1ns/1ps
module cms_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_in,
  input  wire             rst_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output reg              out_valid_out,
  input  wire             out_ready_in,
  output reg  [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Honest full: the store refuses when every slot holds a word
  assign in_ready_out = (count_q != DEPTH[AW:0]);
  assign push         = in_valid_in & in_ready_out;
  // Refill the output stage when it is empty or being drained
  assign pop          = (count_q != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);

  // ----------------------------------------------------------------------
  // Storage array, no reset needed for data
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // Pointers, count and registered output stage
  // ----------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ptr_q      <= {AW{1'b0}};
      rd_ptr_q      <= {AW{1'b0}};
      count_q       <= {(AW+1){1'b0}};
      out_valid_out <= 1'b0;
      out_data_out  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q     <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_out <= mem_q[rd_ptr_q];
      end
      if (push & ~pop) begin
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end

endmodule

// file: cms_scanner.v
// Purpose : CRC memory scanner: walks flash or EEPROM and feeds the CRC engine.
// Assumes : Arbiter grant pulse completes the read at mem_addr_out that cycle.
// Notes   : Byte-wide register port; read data appear one cycle after strobe.
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_scanner #(
  parameter DATA_W = 16,
  parameter FIFO_D = 16,
  parameter FIFO_A = 4,
  parameter TRIG_N = 12
) (
  input  wire              clk_sys_in,
  input  wire              rst_n_in,
  // Register port
  input  wire [11:0]       reg_addr_in,
  input  wire [7:0]        reg_wdata_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  output reg  [7:0]        reg_rdata_out,
  // CRC engine status and data path
  input  wire              crc_go_a_in,
  input  wire              crc_ready_in,
  output wire              crc_valid_out,
  output wire [DATA_W-1:0] crc_data_out,
  output reg  [31:0]       poly_taps_out,
  // System memory arbiter
  output reg               mem_req_out,
  output reg  [21:0]       mem_addr_out,
  output reg               mem_region_out,
  input  wire              mem_grant_in,
  input  wire [DATA_W-1:0] mem_rdata_in,
  // Trigger sources, bit index equals source code
  input  wire [TRIG_N-1:0] trig_src_in
);

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  reg              en_q;
  reg              scanner_trigger_enable_q;
  reg              go_q;
  reg              go_d;
  reg              region_q;
  reg              burst_q;
  reg              busy_q;
  reg  [3:0]       trigger_source_code_q;
  reg  [21:0]      cur_q;
  reg  [21:0]      end_q;
  reg              trig_prev_q;
  reg              trig_pend_q;
  reg              req_d;
  reg  [7:0]       rdata_d;
  wire [TRIG_N-1:0] trig_sync;
  wire             trig_level;
  wire             trig_rise;
  wire             fifo_ready;
  wire             fetch_ok;
  wire             past_end;
  wire             active;
  wire             wr_ctrl;
  wire             wr_addr_ok;

  // Control reset word kept whole so that single fields can be picked from
  // it without cutting a wider constant into a one-bit register
  localparam [7:0] CTRL_RST = `CMS_CTRL_RST;

  // ----------------------------------------------------------------------
  // Trigger inputs: synchronise, select, detect
  // ----------------------------------------------------------------------
  // Sources run from other clocks, so every one is synchronised first
  cms_sync #(
    .WIDTH (TRIG_N)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (trig_src_in),
    .sync_out   (trig_sync)
  );

  // Unused codes select a constant low, so they never fire
  assign trig_level = (trigger_source_code_q <= `CMS_TRIG_USED) ? trig_sync[trigger_source_code_q] : 1'b0;
  assign trig_rise  = trig_level & ~trig_prev_q;

  // ----------------------------------------------------------------------
  // Fetch path
  // ----------------------------------------------------------------------
  // Scanner runs only while enabled and go is set
  assign active   = en_q & go_q;
  assign past_end = (cur_q > end_q);
  // A grant is taken only while the FIFO has room; a grant seen with a full
  // FIFO is let pass and the same address is fetched again later.
  assign fetch_ok = mem_req_out & mem_grant_in & fifo_ready;

  // Fetched words wait here until the CRC engine takes them
  cms_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_A)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (fetch_ok),
    .in_ready_out  (fifo_ready),
    .in_data_in    (mem_rdata_in),
    .out_valid_out (crc_valid_out),
    .out_ready_in  (crc_ready_in),
    .out_data_out  (crc_data_out)
  );

  // ----------------------------------------------------------------------
  // Request generation
  // ----------------------------------------------------------------------
  // The request is registered; the CRC path counts as able to accept data
  // while the FIFO has room. A word granted in this cycle ends the request
  // so only one access is outstanding in the non-burst modes.
  always @* begin
    req_d = 1'b0;
    if (active && !past_end && go_d) begin
      if (burst_q) begin
        // Burst holds the request, but a word taken at the end address must
        // close it now: the registered request would otherwise stay up one
        // more cycle and fetch the location past the end.
        req_d = ~(fetch_ok & (cur_q == end_q));
      end else if (scanner_trigger_enable_q) begin
        req_d = fifo_ready & (trig_pend_q | trig_rise) & ~fetch_ok;
      end else begin
        req_d = fifo_ready & ~fetch_ok;
      end
    end
  end

  // Sticky trigger: one edge arms exactly one fetch; a new edge wins
  // over the clear of the same cycle so no trigger is lost
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      trig_prev_q <= 1'b0;
      trig_pend_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
      if (trig_rise) begin
        trig_pend_q <= 1'b1;
      end else if (fetch_ok || !active) begin
        trig_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Go bit next value
  // ----------------------------------------------------------------------
  // Software write sets or clears; hardware clears at end of scan or when
  // the CRC engine stops. End only counts with no fetch in flight.
  always @* begin
    go_d = go_q;
    if (wr_ctrl) begin
      go_d = reg_wdata_in[`CMS_BIT_GO];
    end
    if (go_q && past_end && !mem_req_out) begin
      go_d = 1'b0;
    end
    if (!crc_go_a_in) begin
      go_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign wr_ctrl    = reg_wr_in & (reg_addr_in == `CMS_OFS_CTRL);
  // Address registers are locked while a scan is set up or running
  assign wr_addr_ok = reg_wr_in & ~go_q;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      poly_taps_out <= `CMS_POLY_RST;
      en_q          <= 1'b0;
      scanner_trigger_enable_q      <= 1'b0;
      go_q          <= 1'b0;
      region_q      <= CTRL_RST[`CMS_BIT_REGION];
      burst_q       <= 1'b0;
      trigger_source_code_q        <= `CMS_TRIGGER_SOURCE_CODE_RST;
      cur_q         <= `CMS_CUR_RST;
      end_q         <= `CMS_END_RST;
    end else begin
      go_q <= go_d;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `CMS_OFS_POLY_L: poly_taps_out[7:0]   <= reg_wdata_in;
          `CMS_OFS_POLY_H: poly_taps_out[15:8]  <= reg_wdata_in;
          `CMS_OFS_POLY_U: poly_taps_out[23:16] <= reg_wdata_in;
          `CMS_OFS_POLY_T: poly_taps_out[31:24] <= reg_wdata_in;
          `CMS_OFS_CTRL: begin
            // Clearing enable touches no other register
            en_q     <= reg_wdata_in[`CMS_BIT_EN];
            scanner_trigger_enable_q <= reg_wdata_in[`CMS_BIT_SCANNER_TRIGGER_ENABLE];
            region_q <= reg_wdata_in[`CMS_BIT_REGION];
            burst_q  <= reg_wdata_in[`CMS_BIT_BURST];
          end
          `CMS_OFS_TRIGGER_SOURCE_CODE: trigger_source_code_q <= reg_wdata_in[3:0];
          default: begin
          end
        endcase
      end
      // Address bytes: ignored while go is set
      if (wr_addr_ok) begin
        case (reg_addr_in)
          `CMS_OFS_CUR_L: cur_q[7:0]   <= reg_wdata_in;
          `CMS_OFS_CUR_H: cur_q[15:8]  <= reg_wdata_in;
          `CMS_OFS_CUR_U: cur_q[21:16] <= reg_wdata_in[5:0];
          `CMS_OFS_END_L: end_q[7:0]   <= reg_wdata_in;
          `CMS_OFS_END_H: end_q[15:8]  <= reg_wdata_in;
          `CMS_OFS_END_U: end_q[21:16] <= reg_wdata_in[5:0];
          default: begin
          end
        endcase
      end else if (fetch_ok) begin
        // Each delivered word advances the walk by one location
        cur_q <= cur_q + 22'h00_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Arbiter side outputs
  // ----------------------------------------------------------------------
  // Busy mirrors an open access, so it drops as soon as the cycle ends
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mem_req_out    <= 1'b0;
      busy_q         <= 1'b0;
      mem_addr_out   <= `CMS_CUR_RST;
      mem_region_out <= CTRL_RST[`CMS_BIT_REGION];
    end else begin
      mem_req_out    <= req_d;
      busy_q         <= req_d;
      mem_region_out <= region_q;
      // Address follows the counter, including the step after a fetch
      if (fetch_ok && !wr_addr_ok) begin
        mem_addr_out <= cur_q + 22'h00_0001;
      end else begin
        mem_addr_out <= cur_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  // Unmapped offsets read zero; reserved control bits read zero
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_in)
      `CMS_OFS_POLY_L: rdata_d = poly_taps_out[7:0];
      `CMS_OFS_POLY_H: rdata_d = poly_taps_out[15:8];
      `CMS_OFS_POLY_U: rdata_d = poly_taps_out[23:16];
      `CMS_OFS_POLY_T: rdata_d = poly_taps_out[31:24];
      `CMS_OFS_CTRL: begin
        rdata_d[`CMS_BIT_EN]     = en_q;
        rdata_d[`CMS_BIT_SCANNER_TRIGGER_ENABLE] = scanner_trigger_enable_q;
        rdata_d[`CMS_BIT_GO]     = go_q;
        rdata_d[`CMS_BIT_REGION] = region_q;
        rdata_d[`CMS_BIT_BURST]  = burst_q;
        rdata_d[`CMS_BIT_BUSY]   = busy_q;
      end
      `CMS_OFS_TRIGGER_SOURCE_CODE:  rdata_d = {4'h0, trigger_source_code_q};
      `CMS_OFS_CUR_L: rdata_d = cur_q[7:0];
      `CMS_OFS_CUR_H: rdata_d = cur_q[15:8];
      `CMS_OFS_CUR_U: rdata_d = {2'b00, cur_q[21:16]};
      `CMS_OFS_END_L: rdata_d = end_q[7:0];
      `CMS_OFS_END_H: rdata_d = end_q[15:8];
      `CMS_OFS_END_U: rdata_d = {2'b00, end_q[21:16]};
      default:        rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

// file: cms_scanner_asserts.sv
// Purpose : Port-level checks for the CRC memory scanner.
// Assumes : One clock, synchronous active-low reset.
// Notes   : Sees only top ports; bound below to every scanner instance.
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_scanner_asserts #(
  parameter DATA_W = 16,
  parameter TRIG_N = 12
) (
  input wire              clk_sys_in,
  input wire              rst_n_in,
  input wire [11:0]       reg_addr_in,
  input wire [7:0]        reg_wdata_in,
  input wire              reg_wr_in,
  input wire              reg_rd_in,
  input wire [7:0]        reg_rdata_out,
  input wire              crc_go_a_in,
  input wire              crc_ready_in,
  input wire              crc_valid_out,
  input wire [DATA_W-1:0] crc_data_out,
  input wire [31:0]       poly_taps_out,
  input wire              mem_req_out,
  input wire [21:0]       mem_addr_out,
  input wire              mem_region_out,
  input wire              mem_grant_in,
  input wire [DATA_W-1:0] mem_rdata_in,
  input wire [TRIG_N-1:0] trig_src_in
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------------
  sequence crc_stop_s;
    !crc_go_a_in ##1 !crc_go_a_in;
  endsequence
  sequence ctrl_read_s;
    reg_rd_in && reg_addr_in == `CMS_OFS_CTRL;
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  // Outputs still show reset values at the first edge after release
  poly_rst_a: assert property ($rose(rst_n_in) |-> poly_taps_out == 32'h0)
    else $error("poly taps not zero after reset");
  region_rst_a: assert property ($rose(rst_n_in) |-> mem_region_out)
    else $error("region not eeprom after reset");
  req_rst_a: assert property ($rose(rst_n_in) |-> !mem_req_out)
    else $error("request open after reset");
  poly_write_a: assert property (reg_wr_in && reg_addr_in == `CMS_OFS_POLY_T
    |=> poly_taps_out[31:24] == $past(reg_wdata_in)) else $error("poly top write lost");
  poly_read_a: assert property (reg_rd_in && reg_addr_in == `CMS_OFS_POLY_L
    |=> reg_rdata_out == $past(poly_taps_out[7:0])) else $error("poly low read wrong");
  busy_read_a: assert property (ctrl_read_s
    |=> reg_rdata_out[`CMS_BIT_BUSY] == $past(mem_req_out)) else $error("busy bit wrong");
  // Address moves only by one, after a grant, unless software wrote it
  addr_step_a: assert property ($changed(mem_addr_out) && !$past(reg_wr_in)
    && !$past(reg_wr_in, 2) |-> mem_addr_out == $past(mem_addr_out) + 22'h1
    && $past(mem_grant_in)) else $error("fetch address jumped");
  go_stop_a: assert property (crc_stop_s |=> !mem_req_out)
    else $error("request kept after crc stop");
  word_hold_a: assert property (crc_valid_out && !crc_ready_in
    |=> crc_valid_out && $stable(crc_data_out)) else $error("crc word dropped");
endmodule

bind cms_scanner cms_scanner_asserts #(.DATA_W(DATA_W), .TRIG_N(TRIG_N)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .crc_go_a_in(crc_go_a_in), .crc_ready_in(crc_ready_in),
  .crc_valid_out(crc_valid_out), .crc_data_out(crc_data_out),
  .poly_taps_out(poly_taps_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
  .mem_region_out(mem_region_out), .mem_grant_in(mem_grant_in),
  .mem_rdata_in(mem_rdata_in), .trig_src_in(trig_src_in));

// file: cms_partner.sv
// Purpose : Arbiter and CRC engine model at the scanner's far side.
// Assumes : Same clock as the scanner.
// Notes   : Grant and ready rates set by the bench, in percent.
`timescale 1ns/1ps
module cms_partner (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        mem_req_in,
  input  wire [21:0] mem_addr_in,
  input  wire        mem_region_in,
  input  wire        crc_valid_in,
  input  wire [7:0]  grant_pct_in,
  input  wire [7:0]  ready_pct_in,
  output wire        mem_grant_out,
  output wire [15:0] mem_rdata_out,
  output reg         crc_ready_out,
  output wire        took_out
);
  reg         win_q;
  wire [15:0] word = mem_addr_in[15:0] ^ {mem_region_in, 15'h0} ^ 16'h5a5a;
  // A random free slot stands for no higher-priority master pending
  always @(posedge clk_sys_in) begin
    win_q         <= rst_n_in && ($urandom % 100 < grant_pct_in);
    crc_ready_out <= rst_n_in && ($urandom % 100 < ready_pct_in);
  end
  assign mem_grant_out = mem_req_in & win_q;
  // Bus shows the inverse outside a grant, so a late sample is caught
  assign mem_rdata_out = mem_grant_out ? word : ~word;
  assign took_out      = crc_valid_in & crc_ready_out;
endmodule

// file: cms_scanner_tb_top.sv
// Purpose : Self-checking bench for the CRC memory scanner.
// Assumes : Partner model plays arbiter and CRC engine.
// Notes   : Random traffic from a fixed seed plus hand-picked corners.
`timescale 1ns/1ps
`include "cms_defs.vh"
module cms_scanner_tb_top;
  reg         clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, crc_go_a_in, reg_rg;
  reg  [11:0] reg_addr_in, trig_src_in;
  reg  [7:0]  reg_wdata_in, grant_pct, ready_pct, d;
  reg  [21:0] exp_a;
  reg  [23:0] g;
  reg  [31:0] p;
  wire [7:0]  reg_rdata_out;
  wire [15:0] crc_data_out, mem_rdata_in;
  wire [31:0] poly_taps_out;
  wire [21:0] mem_addr_out;
  wire        crc_valid_out, mem_req_out, mem_region_out, mem_grant_in, crc_ready_in, took;
  integer     error_cnt, samples_checked, rx_n, i, k, j;

  cms_scanner dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .crc_go_a_in(crc_go_a_in), .crc_ready_in(crc_ready_in),
    .crc_valid_out(crc_valid_out), .crc_data_out(crc_data_out),
    .poly_taps_out(poly_taps_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
    .mem_region_out(mem_region_out), .mem_grant_in(mem_grant_in),
    .mem_rdata_in(mem_rdata_in), .trig_src_in(trig_src_in));
  cms_partner u_far (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mem_req_in(mem_req_out),
    .mem_addr_in(mem_addr_out), .mem_region_in(mem_region_out), .crc_valid_in(crc_valid_out),
    .grant_pct_in(grant_pct), .ready_pct_in(ready_pct), .mem_grant_out(mem_grant_in),
    .mem_rdata_out(mem_rdata_in), .crc_ready_out(crc_ready_in), .took_out(took));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1; reg_addr_in <= a; reg_wdata_in <= v;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [11:0] a, output [7:0] v);
    begin
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b1; reg_addr_in <= a;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
    end
  endtask
  function [15:0] word(input [21:0] a, input r);
    word = a[15:0] ^ {r, 15'h0} ^ 16'h5a5a;
  endfunction
  function [7:0] rst_byte(input [11:0] a);
    case (a)
      `CMS_OFS_CTRL:                  rst_byte = `CMS_CTRL_RST;
      `CMS_OFS_END_L, `CMS_OFS_END_H: rst_byte = 8'hff;
      `CMS_OFS_END_U:                 rst_byte = 8'h3f;
      default:                        rst_byte = 8'h00;
    endcase
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Every word handed to the CRC side must follow the fetch order
  always @(posedge clk_sys_in) if (took === 1'b1) begin
    chk("crc word", word(exp_a, reg_rg), crc_data_out);
    exp_a = exp_a + 22'h1;
    rx_n  = rx_n + 1;
  end

  // One scan: program window, start, poll go, check count and address
  task run(input [7:0] c, input [21:0] s, input [21:0] n, input [3:0] code);
    reg [21:0] e;
    begin
      e = s + n - 22'h1; exp_a = s; rx_n = 0; reg_rg = c[2]; trig_src_in <= 12'h0;
      for (k = 0; k < 3; k = k + 1) wr(12'(`CMS_OFS_CUR_L + k), 8'(s >> (8 * k)));
      for (k = 0; k < 3; k = k + 1) wr(12'(`CMS_OFS_END_L + k), 8'(e >> (8 * k)));
      wr(`CMS_OFS_TRIGGER_SOURCE_CODE, {4'h0, code});
      wr(`CMS_OFS_CTRL, c);
      wr(`CMS_OFS_CUR_L, 8'h55);
      for (i = 0; i < 4000 && rx_n < n; i = i + 1) begin
        // Only the selected source toggles; burst must not need it
        if (c[6] && !c[1] && i % 16 == 8) trig_src_in <= trig_src_in ^ (12'h1 << code);
        @(posedge clk_sys_in);
      end
      d = 8'hff;
      for (i = 0; i < 50 && d[`CMS_BIT_GO] !== 1'b0; i = i + 1) rd(`CMS_OFS_CTRL, d);
      chk("go cleared", 0, d[`CMS_BIT_GO]);
      chk("busy idle", 0, d[`CMS_BIT_BUSY]);
      repeat (4) @(posedge clk_sys_in);
      chk("word count", n, rx_n);
      chk("request idle", 0, mem_req_out);
      for (k = 0; k < 3; k = k + 1) rd(12'(`CMS_OFS_CUR_L + k), g[8*k +: 8]);
      chk("current addr", s + n, g);
      $display("scan test done ctrl %h code %0d", c, code);
    end
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #6000000;
    error_cnt = error_cnt + 1;
    close_out;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n_in = 0; reg_wr_in = 0; reg_rd_in = 0; reg_addr_in = 0; reg_wdata_in = 0;
    crc_go_a_in = 0; trig_src_in = 0; grant_pct = 50; ready_pct = 50; reg_rg = 1;
    error_cnt = 0; samples_checked = 0; rx_n = 0; exp_a = 0;
    void'($urandom(11051));
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    // Reset values across the map, holes included
    for (p = `CMS_OFS_POLY_L; p <= `CMS_OFS_END_U; p = p + 1) begin
      rd(12'(p), d);
      chk("reset byte", rst_byte(12'(p)), d);
    end
    $display("reset test done");
    p = $urandom;
    for (k = 0; k < 4; k = k + 1) wr(12'(`CMS_OFS_POLY_L + k), 8'(p >> (8 * k)));
    @(posedge clk_sys_in);
    #1 chk("poly taps", p, poly_taps_out);
    rd(`CMS_OFS_POLY_U, d);
    chk("poly upper", p[23:16], d);
    $display("poly test done");
    crc_go_a_in <= 1'b1;
    run(8'ha0, 22'($urandom % 32'h3f0000), 6, 0);
    run(8'ha4, 22'($urandom % 32'h3f0000), 5, 0);
    run(8'ha0, 22'h00fffe, 4, 0);
    // Slow CRC side fills the buffer while burst keeps asking
    ready_pct = 5;
    run(8'he6, 22'($urandom % 32'h3f0000), 24, 0);
    ready_pct = 50;
    // Own loop index: run steps k itself
    for (j = 0; j < 12; j = j + 1) run(8'he0 | {5'h0, j[0], 2'h0}, 22'($urandom % 32'h3f0000), 2, 4'(j));
    // CRC engine stops mid-scan
    for (k = 0; k < 3; k = k + 1) wr(12'(`CMS_OFS_END_L + k), 8'hff);
    reg_rg = 0;
    wr(`CMS_OFS_CTRL, 8'ha0);
    repeat (20) @(posedge clk_sys_in);
    crc_go_a_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rd(`CMS_OFS_CTRL, d);
    chk("go after crc stop", 0, d[`CMS_BIT_GO]);
    chk("poly kept", p, poly_taps_out);
    crc_go_a_in <= 1'b1;
    // Disable keeps go and every other register
    wr(`CMS_OFS_CTRL, 8'ha0);
    repeat (10) @(posedge clk_sys_in);
    wr(`CMS_OFS_CTRL, 8'h20);
    repeat (5) @(posedge clk_sys_in);
    chk("request when disabled", 0, mem_req_out);
    rd(`CMS_OFS_CTRL, d);
    chk("go kept", 1, d[`CMS_BIT_GO]);
    rd(`CMS_OFS_END_H, d);
    chk("end kept", 8'hff, d);
    chk("poly still kept", p, poly_taps_out);
    wr(`CMS_OFS_CTRL, 8'h00);
    // Unused trigger code never fires; software clears go
    repeat (40) @(posedge clk_sys_in);
    wr(`CMS_OFS_TRIGGER_SOURCE_CODE, 8'h0c);
    wr(`CMS_OFS_CTRL, 8'he0);
    rx_n = 0;
    for (i = 0; i < 100; i = i + 1) begin
      if (i % 16 == 8) trig_src_in <= ~trig_src_in;
      @(posedge clk_sys_in);
    end
    chk("unused trigger", 0, rx_n);
    wr(`CMS_OFS_CTRL, 8'h00);
    rd(`CMS_OFS_CTRL, d);
    chk("go sw clear", 0, d[`CMS_BIT_GO]);
    $display("control test done");
    close_out;
  end
endmodule
